// File: core/bbd_pkg.sv
// shared constants and carrier types for the boost bias control block
package bbd_pkg;

  // ------------------------------------------------------------
  // clocking and oscillator
  // ------------------------------------------------------------
  localparam int CLOCK_HZ = 10_000_000;
  localparam int CLOCK_PERIOD_NS = 100;
  localparam int OSC_NOM_HZ = 300_000;
  localparam int OSC_MIN_KHZ = 240;
  localparam int OSC_MAX_KHZ = 360;
  localparam int OSC_PERIOD_CYCLES = CLOCK_HZ / OSC_NOM_HZ;
  localparam int PHASE_W = 6;
  localparam int GATE_MAX_ON_NS = 3000;
  // longest time: round down
  localparam int GATE_MAX_ON_CYCLES = GATE_MAX_ON_NS / CLOCK_PERIOD_NS;

  // ------------------------------------------------------------
  // level setting and serial frame
  // ------------------------------------------------------------
  localparam int LEVEL_W = 8;
  localparam int FRAME_BITS = 8;
  localparam int BIT_CNT_W = 4;
  localparam int DAC_STEPS = 256;
  localparam int DAC_REF_MV = 1250;
  localparam int LEVEL_OUT_W = $clog2(DAC_STEPS) + 1;
  localparam logic [LEVEL_W-1:0] LEVEL_RESET = 8'hFF;
  localparam logic [LEVEL_W-1:0] LEVEL_SHUTDOWN = 8'h00;
  localparam int LIMIT_THRESHOLD_MV = 2000;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic cs_n;
    logic din;
  } bbd_link_type;

  typedef struct packed {
    logic limit_cmp;
    logic uvlo;
  } bbd_sense_type;

endpackage : bbd_pkg

// File: core/bbd_ctrl.sv
// boost bias supply control: serial level port, pwm and limit flag
//
// Function
// R1 - write-only three-wire link, no data out
// R2 - one 8-bit byte sets level register
// R3 - level register resets to FF hex
// R4 - zero code stops switching, port alive
// R5 - writes accepted always, even in shutdown
// R6 - pull compensation low in shutdown/undervoltage
// R7 - limit flag low in limit, else high
// R8 - limit flag changes only on oscillator edge
// R9 - limit entered when sense threshold reached
// R10 - level output equals code plus one step
// R11 - fixed-frequency pwm sets switch on-time
// R12 - msb first, rising clock, commit on deselect
`timescale 1ns/1ps
`default_nettype none

module bbd_ctrl #(
  parameter int unsigned OSC_PERIOD = bbd_pkg::OSC_PERIOD_CYCLES,
  parameter int unsigned MAX_ON = bbd_pkg::GATE_MAX_ON_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_clock_en,
  input wire logic i_sclk,
  input wire bbd_pkg::bbd_link_type i_link,
  input wire bbd_pkg::bbd_sense_type i_sense,
  input wire logic [bbd_pkg::PHASE_W-1:0] i_duty,
  output logic o_gate,
  output logic o_comp_pull,
  output logic o_limit_flag_n,
  output logic [bbd_pkg::LEVEL_OUT_W-1:0] o_level_voltage_out
);
  import bbd_pkg::*;

  // ------------------------------------------------------------
  // link domain: shifter on the serial clock
  // ------------------------------------------------------------
  logic [BIT_CNT_W-1:0] bit_cnt_reg;
  logic [BIT_CNT_W-1:0] bit_cnt_next;
  logic [LEVEL_W-1:0] shift_reg;
  logic [LEVEL_W-1:0] shift_next;
  logic [LEVEL_W-1:0] hold_reg;
  logic [LEVEL_W-1:0] hold_next;
  logic tgl_reg;
  logic tgl_next;

  // bits past the eighth are ignored; the first byte is kept
  always_comb begin
    bit_cnt_next = bit_cnt_reg;
    shift_next = shift_reg;
    hold_next = hold_reg;
    tgl_next = tgl_reg;
    if (bit_cnt_reg < BIT_CNT_W'(FRAME_BITS)) begin
      shift_next = {shift_reg[LEVEL_W-2:0], i_link.din}; // R12
      bit_cnt_next = bit_cnt_reg + 4'h1;
      if (bit_cnt_reg == BIT_CNT_W'(FRAME_BITS - 1)) begin
        hold_next = {shift_reg[LEVEL_W-2:0], i_link.din}; // R2
        tgl_next = ~tgl_reg;
      end
    end
  end

  // deselect clears the frame; the serial clock is idle then
  always_ff @(posedge i_sclk or posedge i_link.cs_n) begin
    if (i_link.cs_n) begin
      bit_cnt_reg <= '0; // R1
      shift_reg <= '0;
    end else begin
      bit_cnt_reg <= bit_cnt_next;
      shift_reg <= shift_next;
    end
  end

  // no free-running link clock, so reset cannot be synchronous here
  always_ff @(posedge i_sclk or posedge i_rst) begin
    if (i_rst) begin
      hold_reg <= '0;
      tgl_reg <= 1'b0;
    end else begin
      hold_reg <= hold_next;
      tgl_reg <= tgl_next;
    end
  end

  // ------------------------------------------------------------
  // crossings into the system clock
  // ------------------------------------------------------------
  logic cs_meta_reg;
  logic cs_sync_reg;
  logic tgl_meta_reg;
  logic tgl_sync_reg;
  logic lim_meta_reg;
  logic lim_sync_reg;
  logic uv_meta_reg;
  logic uv_sync_reg;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      cs_meta_reg <= 1'b1;
      cs_sync_reg <= 1'b1;
      tgl_meta_reg <= 1'b0;
      tgl_sync_reg <= 1'b0;
      lim_meta_reg <= 1'b0;
      lim_sync_reg <= 1'b0;
      uv_meta_reg <= 1'b1;
      uv_sync_reg <= 1'b1;
    end else if (i_clock_en) begin
      cs_meta_reg <= i_link.cs_n;
      cs_sync_reg <= cs_meta_reg;
      tgl_meta_reg <= tgl_reg;
      tgl_sync_reg <= tgl_meta_reg;
      lim_meta_reg <= i_sense.limit_cmp;
      lim_sync_reg <= lim_meta_reg;
      uv_meta_reg <= i_sense.uvlo;
      uv_sync_reg <= uv_meta_reg;
    end
  end

  // ------------------------------------------------------------
  // level register
  // ------------------------------------------------------------
  logic [LEVEL_W-1:0] level_reg;
  logic [LEVEL_W-1:0] level_next;
  logic seen_reg;
  logic seen_next;
  logic cs_idle;
  logic pending;

  // level, not edge: a frame sent while frozen still lands after
  assign cs_idle = cs_sync_reg;
  assign pending = tgl_sync_reg ^ seen_reg;

  // commit does not look at shutdown state, so writes always land
  always_comb begin
    level_next = level_reg;
    seen_next = seen_reg;
    if (cs_idle && pending) begin
      level_next = hold_reg; // R12 R5
      seen_next = tgl_sync_reg;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      level_reg <= LEVEL_RESET; // R3
      seen_reg <= 1'b0;
    end else if (i_clock_en) begin
      level_reg <= level_next;
      seen_reg <= seen_next;
    end
  end

  // ------------------------------------------------------------
  // oscillator, pwm and limit flag
  // ------------------------------------------------------------
  logic [PHASE_W-1:0] phase_reg;
  logic [PHASE_W-1:0] phase_next;
  logic lim_cyc_reg;
  logic lim_cyc_next;
  logic flag_n_reg;
  logic flag_n_next;
  logic gate_reg;
  logic gate_next;
  logic [LEVEL_OUT_W-1:0] lvl_out_reg;
  logic [LEVEL_OUT_W-1:0] lvl_out_next;
  logic osc_tick;
  logic shutdown;
  logic run;
  logic [PHASE_W-1:0] duty_cap;

  assign osc_tick = phase_reg == PHASE_W'(OSC_PERIOD - 1);
  assign shutdown = level_reg == LEVEL_SHUTDOWN;
  assign run = ~shutdown & ~uv_sync_reg;
  assign duty_cap = (i_duty > PHASE_W'(MAX_ON)) ? PHASE_W'(MAX_ON) : i_duty;

  always_comb begin
    phase_next = osc_tick ? '0 : phase_reg + 6'h01; // R11
    // cycle-by-cycle limit; a trip at the wrap carries into the next cycle
    lim_cyc_next = lim_sync_reg | (~osc_tick & lim_cyc_reg); // R9
    flag_n_next = flag_n_reg;
    if (osc_tick) begin
      flag_n_next = ~(lim_sync_reg | lim_cyc_reg); // R7 R8
    end
    gate_next = run & ~lim_sync_reg & ~lim_cyc_reg
      & (phase_next < duty_cap); // R4 R11 R9
    lvl_out_next = {1'b0, level_reg} + 9'h001; // R10
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      phase_reg <= '0;
      lim_cyc_reg <= 1'b0;
      flag_n_reg <= 1'b1;
      gate_reg <= 1'b0;
      lvl_out_reg <= {1'b0, LEVEL_RESET} + 9'h001;
    end else if (i_clock_en) begin
      phase_reg <= phase_next;
      lim_cyc_reg <= lim_cyc_next;
      flag_n_reg <= flag_n_next;
      gate_reg <= gate_next;
      lvl_out_reg <= lvl_out_next;
    end
  end

  assign o_gate = gate_reg;
  assign o_limit_flag_n = flag_n_reg;
  assign o_level_voltage_out = lvl_out_reg;
  assign o_comp_pull = shutdown | uv_sync_reg; // R6

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  localparam int OSC_GAP = int'(OSC_PERIOD) - 1;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst || !i_clock_en);

  sequence commit_s;
    cs_idle && pending;
  endsequence

  sequence tick_s;
    osc_tick;
  endsequence

  reset_level_a: assert property ( // R3
    $past(i_rst) |-> level_reg == 8'hFF && o_level_voltage_out == 9'h100)
    else $error("level not full scale after reset");

  commit_byte_a: assert property ( // R12
    commit_s |=> level_reg == $past(hold_reg))
    else $error("byte not committed on deselect");

  shutdown_write_a: assert property ( // R5
    shutdown ##0 commit_s |=> level_reg == $past(hold_reg))
    else $error("write refused during shutdown");

  shutdown_gate_a: assert property ( // R4
    shutdown |=> !o_gate)
    else $error("switching while shut down");

  comp_pull_a: assert property ( // R6
    (uv_sync_reg || level_reg == 8'h00) |-> o_comp_pull)
    else $error("compensation not pulled low");

  flag_hold_a: assert property ( // R8
    !osc_tick |=> $stable(o_limit_flag_n))
    else $error("limit flag moved between oscillator edges");

  flag_value_a: assert property ( // R7
    tick_s ##0 lim_sync_reg |=> !o_limit_flag_n)
    else $error("limit flag not low in current limit");

  limit_gate_a: assert property ( // R9
    lim_sync_reg |=> !o_gate)
    else $error("gate on during current limit");

  level_out_a: assert property ( // R10
    ##1 o_level_voltage_out == {1'b0, $past(level_reg)} + 9'h001)
    else $error("level output not code plus one step");

  osc_period_a: assert property ( // R11
    tick_s |=> !osc_tick ##[OSC_GAP:OSC_GAP] osc_tick)
    else $error("oscillator period out of bound");

  sequence limit_s;
    lim_sync_reg;
  endsequence

  gate_on_cap_a: assert property ( // R11
    o_gate |-> phase_reg < PHASE_W'(MAX_ON))
    else $error("gate on past the on-time cap");

  gate_run_a: assert property ( // R4
    o_gate |-> $past(run))
    else $error("gate on while converter stopped");

  comp_gate_a: assert property ( // R6
    o_comp_pull |=> !o_gate)
    else $error("gate on while compensation pulled");

  limit_cycle_a: assert property ( // R9
    limit_s |-> ##2 !o_gate)
    else $error("gate back on within a limited cycle");

  flag_clear_a: assert property ( // R7
    tick_s ##0 (!lim_sync_reg && !lim_cyc_reg) |=> o_limit_flag_n)
    else $error("limit flag low without current limit");

  flag_tick_a: assert property ( // R8
    $changed(o_limit_flag_n) |-> $past(osc_tick))
    else $error("limit flag changed off an oscillator edge");

  phase_wrap_a: assert property ( // R11
    tick_s |=> phase_reg == '0)
    else $error("oscillator phase not wrapped");

  level_hold_a: assert property ( // R12
    !(cs_idle && pending) |=> $stable(level_reg))
    else $error("level moved without a committed frame");

  level_code_a: assert property ( // R10
    commit_s |-> ##2
      o_level_voltage_out == {1'b0, $past(hold_reg, 2)} + 9'h001)
    else $error("level output not byte plus one step");

endmodule : bbd_ctrl

`default_nettype wire

// File: verif/bbd_host_model.sv
// host serial master model for the level port
`timescale 1ns/1ps
`default_nettype none
module bbd_host_model (
  output var logic o_sclk,
  output var bbd_pkg::bbd_link_type o_link
);
  import bbd_pkg::*;
  initial begin
    o_sclk = 1'b0;
    o_link = '{cs_n: 1'b1, din: 1'b1};
  end
  // msb first; the link has no data out, write only
  task automatic send(input logic [15:0] word, input int nbits);
    o_link.cs_n = 1'b0;
    #200;
    for (int i = 0; i < nbits; i++) begin
      o_link.din = word[15-i];
      #62.5 o_sclk = 1'b1;
      #62.5 o_sclk = 1'b0;
    end
    #200 o_link.cs_n = 1'b1;
    // released line: inverse, not a stale copy
    o_link.din = ~o_link.din;
    #300;
  endtask : send
endmodule : bbd_host_model
`default_nettype wire

// File: verif/bbd_ctrl_test.sv
// self-checking bench for the boost bias control block
`timescale 1ns/1ps
`default_nettype none
module bbd_ctrl_test;
  import bbd_pkg::*;
  typedef struct packed {
    logic [15:0] word;
    logic [4:0] nbits;
    logic [8:0] exp;
  } bbd_row_type;
  logic i_clock, i_rst, i_clock_en, sclk, gate, comp_pull, flag_n, prev_n;
  bbd_link_type link;
  bbd_sense_type sense;
  logic [PHASE_W-1:0] duty;
  logic [LEVEL_OUT_W-1:0] level_out;
  int miscompares, checked, highs, cyc, last_t, step;
  bbd_row_type rows [6] = '{
    '{16'h0000, 5'd8, 9'h001}, '{16'h0100, 5'd8, 9'h002},
    '{16'hA500, 5'd5, 9'h002}, '{16'h5AC3, 5'd16, 9'h05B},
    '{16'h8000, 5'd8, 9'h081}, '{16'hFF00, 5'd8, 9'h100}};

  bbd_host_model i_host (.o_sclk(sclk), .o_link(link));
  bbd_ctrl i_dut (.i_clock(i_clock), .i_rst(i_rst),
    .i_clock_en(i_clock_en), .i_sclk(sclk), .i_link(link),
    .i_sense(sense), .i_duty(duty), .o_gate(gate),
    .o_comp_pull(comp_pull), .o_limit_flag_n(flag_n),
    .o_level_voltage_out(level_out));

  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end

  task automatic check(input string name, input logic [8:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
    #10;
  endtask : tick

  task automatic count_gate(input int n);
    highs = 0;
    repeat (n) begin
      tick(1);
      highs += int'(gate === 1'b1);
    end
  endtask : count_gate

  task automatic test_done;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  // ------------------------------------------------------------
  // flag edges must sit whole oscillator periods apart
  // ------------------------------------------------------------
  always @(negedge i_clock) begin
    cyc++;
    if (!i_rst && prev_n !== flag_n) begin
      step = (cyc - last_t) % OSC_PERIOD_CYCLES;
      if (last_t > 0) check("flag_step", 9'(step), 9'h000);
      last_t = cyc;
    end
    prev_n = flag_n;
  end

  initial begin
    #1_000_000;
    miscompares++;
    test_done();
  end

  initial begin
    i_rst = 1'b1;
    i_clock_en = 1'b1;
    sense = '{limit_cmp: 1'b0, uvlo: 1'b0};
    duty = 6'h0A;
    tick(5);
    i_rst = 1'b0;
    tick(1);
    check("level_rst", level_out, 9'h100);
    check("flag_rst", flag_n, 9'h001);
    foreach (rows[k]) begin
      i_host.send(rows[k].word, int'(rows[k].nbits));
      tick(8);
      check("level", level_out, rows[k].exp);
      check("comp_pull", comp_pull, 9'(rows[k].exp == 9'h001));
    end
    tick(33);
    count_gate(66);
    check("gate_on", 9'(highs), 9'd20);
    duty = 6'h3F;
    tick(33);
    count_gate(66);
    check("gate_cap", 9'(highs), 9'd60);
    sense.limit_cmp = 1'b1;
    tick(70);
    check("flag_lim", flag_n, 9'h000);
    count_gate(33);
    check("lim_gate", 9'(highs), 9'd0);
    sense.limit_cmp = 1'b0;
    tick(70);
    check("flag_clr", flag_n, 9'h001);
    sense.uvlo = 1'b1;
    tick(3);
    count_gate(33);
    check("uvlo_pull", comp_pull, 9'h001);
    check("uvlo_gate", 9'(highs), 9'd0);
    sense.uvlo = 1'b0;
    i_host.send(16'h0000, 8);
    tick(8);
    count_gate(66);
    check("off_gate", 9'(highs), 9'd0);
    i_clock_en = 1'b0;
    i_host.send(16'h4000, 8);
    tick(10);
    check("frozen", level_out, 9'h001);
    i_clock_en = 1'b1;
    tick(8);
    check("thawed", level_out, 9'h041);
    // second reset in mid-run, then the port must still take writes
    i_rst = 1'b1;
    tick(2);
    check("rst_flag", flag_n, 9'h001);
    i_rst = 1'b0;
    tick(1);
    check("level_rerst", level_out, 9'h100);
    check("pull_rerst", comp_pull, 9'h001);
    i_host.send(16'h3000, 8);
    tick(8);
    check("post_rst", level_out, 9'h031);
    check("pull_run", comp_pull, 9'h000);
    test_done();
  end
endmodule : bbd_ctrl_test
`default_nettype wire
